// >>> sli_pkg.sv
package sli_pkg;
   // timing figures in their own units and the derived cycle counts at 125 MHz
   localparam int unsigned CLK_HZ         = 125_000_000;
   localparam int unsigned FAST_MS        = 500;
   localparam int unsigned SLOW_MS        = 1000;
   localparam int unsigned BURST_S        = 8;
   localparam int unsigned FLASH_MS       = 250;
   localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
   localparam int unsigned FAST_CYCLES    = FAST_MS * MS_CYCLES;
   localparam int unsigned SLOW_CYCLES    = SLOW_MS * MS_CYCLES;
   localparam int unsigned FLASH_CYCLES   = FLASH_MS * MS_CYCLES;
   localparam int unsigned BURST_TICKS    = BURST_S * 1000 / FLASH_MS;
   localparam int unsigned ERR_W          = 8;
   localparam int unsigned TICK_W         = 32;
   // reset values
   localparam logic        LAMP_RST       = 1'b0;
   localparam logic [4:0]  ST_RST         = 5'h01;

   typedef enum logic [4:0] {
      SLI_ST_INIT  = 5'h01,
      SLI_ST_CHECK = 5'h02,
      SLI_ST_RUN   = 5'h04,
      SLI_ST_HALT  = 5'h08,
      SLI_ST_SPARE = 5'h10
   } sli_state_t;
endpackage

// >>> sli_tick_if.sv
`timescale 1ns/1ps
// carries the fixed-period enable pulses between the divider and the lamp logic
interface sli_tick_if;
   logic fast_tick;
   logic slow_tick;
   logic flash_tick;
   modport src (output fast_tick, output slow_tick, output flash_tick);
   modport dst (input fast_tick, input slow_tick, input flash_tick);
endinterface

// >>> sli_divider.sv
`timescale 1ns/1ps
// one-cycle enable pulse every PERIOD clocks
module sli_divider #(
   parameter int unsigned PERIOD = 2
) (
   input  wire logic  clk_sys,
   input  wire logic  rst_n,
   output logic       tick
);
   logic [sli_pkg::TICK_W-1:0] cnt_reg;

   // free-running count, wraps at the period
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (cnt_reg == sli_pkg::TICK_W'(PERIOD - 1)) begin
         cnt_reg <= '0;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         tick    <= 1'b0;
      end
   end
endmodule // sli_divider

// >>> sli_status_lamps.sv
`timescale 1ns/1ps
// Contract
// - red lamp toggles every 500 ms while battery is low or absent; only batt_low drives it here, there is no battery-absent input
// - red lamp toggles every second during upgrade or without firmware
// - on fault, red flashes error-count times, burst repeats every 8 seconds; here only the low 7 bits of the count are used, giving at most 16 flashes
// - amber lamp steady on only during online debug with breakpoints
// - green lamp off while I/O configuration is not loaded
// - green lamp off during a firmware upgrade
// - green lamp off while a debug session is online
// - green lamp off while faulted or in error
// - run state entered only after memory, bus and battery checks pass
module sli_status_lamps (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic                    batt_low,
   input  wire logic                    fw_upgrade,
   input  wire logic                    fw_absent,
   input  wire logic                    faulted,
   input  wire logic [sli_pkg::ERR_W-1:0] err_count,
   input  wire logic                    debug_online,
   input  wire logic                    debug_brk,
   input  wire logic                    io_configured,
   input  wire logic                    chk_done,
   input  wire logic                    chk_mem_ok,
   input  wire logic                    chk_bus_ok,
   input  wire logic                    chk_batt_ok,
   output logic                         run_en,
   output logic                         lamp_red,
   output logic                         lamp_amber,
   output logic                         lamp_green
);
   sli_tick_if ticks ();
   sli_pkg::sli_state_t state_reg;
   logic                      fast_ph_reg;
   logic                      slow_ph_reg;
   logic [5:0]                slot_reg;
   logic [sli_pkg::ERR_W-1:0] flashes_reg;
   logic                      flash_lit;
   logic                      red_next;
   logic                      green_next;
   logic                      amber_next;
   logic                      in_run;
   logic                      fw_busy;
   logic                      burst_end;

   // three fixed-period enables, all from the one system clock
   // fast blink: half period of the battery warning
   sli_divider #(.PERIOD(sli_pkg::FAST_CYCLES)) u_fast (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (ticks.fast_tick)
   );

   // slow blink: half period of the firmware warning
   sli_divider #(.PERIOD(sli_pkg::SLOW_CYCLES)) u_slow (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (ticks.slow_tick)
   );

   // flash slot: one quarter second of the error burst
   sli_divider #(.PERIOD(sli_pkg::FLASH_CYCLES)) u_flash (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .tick    (ticks.flash_tick)
   );

   // power-up sequence: run only once every self-check passes
   // a failed check parks in halt until the next reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= sli_pkg::SLI_ST_INIT;
      end else begin
         case (state_reg)
            sli_pkg::SLI_ST_INIT: begin
               state_reg <= sli_pkg::SLI_ST_CHECK;
            end
            sli_pkg::SLI_ST_CHECK: begin
               if (chk_done && chk_mem_ok && chk_bus_ok && chk_batt_ok) begin
                  state_reg <= sli_pkg::SLI_ST_RUN;
               end else if (chk_done) begin
                  state_reg <= sli_pkg::SLI_ST_HALT;
               end
            end
            sli_pkg::SLI_ST_RUN: begin
               state_reg <= sli_pkg::SLI_ST_RUN;
            end
            sli_pkg::SLI_ST_HALT: begin
               state_reg <= sli_pkg::SLI_ST_HALT;
            end
            default: begin
               state_reg <= sli_pkg::SLI_ST_INIT; // stray codes restart the sequence
            end
         endcase
      end
   end

   // shared condition decode
   // firmware missing and firmware upgrade share one red pattern
   assign in_run  = (state_reg == sli_pkg::SLI_ST_RUN);
   assign fw_busy = fw_upgrade || fw_absent;

   // fast blink phase for the battery warning
   // free-running, so the first toggle may come early after entry
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fast_ph_reg <= 1'b0;
      end else if (ticks.fast_tick) begin
         fast_ph_reg <= ~fast_ph_reg;
      end
   end

   // slow blink phase for the firmware warning
   // free-running like the fast phase
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slow_ph_reg <= 1'b0;
      end else if (ticks.slow_tick) begin
         slow_ph_reg <= ~slow_ph_reg;
      end
   end

   // last quarter-second slot of the 8 s burst window
   // both the slot counter and the count latch act on it
   assign burst_end = ticks.flash_tick && (slot_reg == 6'(sli_pkg::BURST_TICKS - 1));

   // slot counter: 32 quarter-second slots make one 8 s burst
   // wraps on its own, the burst repeats while the fault stays
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_reg <= '0;
      end else if (burst_end) begin
         slot_reg <= '0;
      end else if (ticks.flash_tick) begin
         slot_reg <= slot_reg + 6'h01;
      end
   end

   // error count is taken once per burst
   // a count that changes mid-burst never cuts the burst short
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flashes_reg <= '0;
      end else if (burst_end) begin
         flashes_reg <= err_count;
      end
   end

   // even slots are lit, one per flash, odd slots are the dark gaps
   // only the low 7 bits of the count are used, and those of 16 or more give 16 flashes per burst
   assign flash_lit = !slot_reg[0] &&
                      ({3'h0, slot_reg[5:1]} < {1'b0, flashes_reg[6:0]});

   // red lamp selection by priority: fault, then firmware, then low battery
   // with no warning active red is steady on, but only in the run state
   // so a halted controller shows a dark red lamp
   always_comb begin
      if (faulted) begin
         red_next = flash_lit;
      end else if (fw_busy) begin
         red_next = slow_ph_reg;
      end else if (batt_low) begin
         red_next = fast_ph_reg;
      end else begin
         red_next = in_run;
      end
   end

   // green only in clean run
   // missing firmware alone does not darken green
   always_comb begin
      green_next = in_run && io_configured
                   && !fw_upgrade
                   && !debug_online
                   && !faulted;
   end

   // amber follows an online debug session that has breakpoints set
   // debug online without breakpoints leaves amber dark
   assign amber_next = debug_online && debug_brk;

   // red lamp driver
   // registered so a decode glitch never reaches the panel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lamp_red <= sli_pkg::LAMP_RST;
      end else begin
         lamp_red <= red_next;
      end
   end

   // amber lamp driver
   // one cycle behind the debug inputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lamp_amber <= sli_pkg::LAMP_RST;
      end else begin
         lamp_amber <= amber_next;
      end
   end

   // green lamp driver
   // one cycle behind the condition inputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lamp_green <= sli_pkg::LAMP_RST;
      end else begin
         lamp_green <= green_next;
      end
   end

   // run indication
   // rises one cycle after the state reaches run and holds until reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_en <= 1'b0;
      end else begin
         run_en <= in_run;
      end
   end
endmodule // sli_status_lamps

// >>> sli_lamps_monitor.sv
`timescale 1ns/1ps
// lamp and run output checks against the condition inputs
module sli_lamps_monitor (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic batt_low,
   input wire logic fw_upgrade,
   input wire logic fw_absent,
   input wire logic faulted,
   input wire logic debug_online,
   input wire logic debug_brk,
   input wire logic io_configured,
   input wire logic chk_done,
   input wire logic chk_mem_ok,
   input wire logic chk_bus_ok,
   input wire logic chk_batt_ok,
   input wire logic run_en,
   input wire logic lamp_red,
   input wire logic lamp_amber,
   input wire logic lamp_green
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   chk_amber_debug: assert property (lamp_amber == $past(debug_online && debug_brk))
      else $error("amber lamp wrong");
   chk_green_noio: assert property (!io_configured |=> !lamp_green)
      else $error("green lit without io");
   chk_green_upg: assert property (fw_upgrade |=> !lamp_green)
      else $error("green lit in upgrade");
   chk_green_dbg: assert property (debug_online |=> !lamp_green)
      else $error("green lit in debug");
   chk_green_flt: assert property (faulted |=> !lamp_green)
      else $error("green lit when faulted");
   chk_run_gate: assert property ($rose(run_en) |-> $past(chk_done && chk_mem_ok && chk_bus_ok
      && chk_batt_ok, 3))
      else $error("run without passing check");
   chk_run_hold: assert property (run_en |=> run_en)
      else $error("run state left");
   chk_normal_run: assert property (run_en && io_configured && !(batt_low | fw_upgrade | fw_absent
      | faulted | debug_online | debug_brk) |=> lamp_red && lamp_green && !lamp_amber)
      else $error("normal lamps wrong");
endmodule // sli_lamps_monitor
bind sli_status_lamps sli_lamps_monitor u_sli_lamps_monitor (.*);

// >>> sli_panel_model.sv
`timescale 1ns/1ps
// operator watching the panel: counts red lamp turn-ons
module sli_panel_model (
   input wire logic  clk_sys,
   input wire logic  rst_n,
   input wire logic  lamp_red,
   output logic [7:0] red_rises
);
   logic red_reg;
   // edge counter, cleared by reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         red_reg <= 1'b0;
         red_rises <= 8'h00;
      end else begin
         red_reg <= lamp_red;
         if (lamp_red && !red_reg) red_rises <= red_rises + 8'h01;
      end
   end
endmodule // sli_panel_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_sys, rst_n, batt_low, fw_upgrade, fw_absent, faulted, debug_online, debug_brk;
   logic io_configured, chk_done, chk_mem_ok, chk_bus_ok, chk_batt_ok;
   logic run_en, lamp_red, lamp_amber, lamp_green;
   logic [sli_pkg::ERR_W-1:0] err_count;
   logic [7:0] red_rises, lfsr;
   logic [7:0] corner [4] = '{8'h7f, 8'h70, 8'h48, 8'h44};
   int miscompares, n_compared, i;
   sli_status_lamps u_sli_status_lamps (.*);
   sli_panel_model u_sli_panel_model (.clk_sys, .rst_n, .lamp_red, .red_rises);
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // bits: 0 batt, 1 upgrade, 2 absent, 3 fault, 4 online, 5 brk, 6 io
   function automatic logic [7:0] lamps_exp(input logic [7:0] s);
      return {5'h00, !(s[0] | s[1] | s[2] | s[3]), s[4] & s[5], s[6] & !(s[1] | s[3] | s[4])};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("compared=%0d miscompares=%0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // drive conditions at the falling edge, one rising edge passes before sampling
   task automatic apply(input logic [7:0] s);
      @(negedge clk_sys);
      {io_configured, debug_brk, debug_online, faulted, fw_absent, fw_upgrade, batt_low} = s[6:0];
      @(negedge clk_sys);
      check({5'h00, lamp_red, lamp_amber, lamp_green}, lamps_exp(s));
   endtask
   // reset with a given check result, then wait a bounded time for run
   task automatic restart(input logic [2:0] ok);
      @(negedge clk_sys);
      rst_n = 1'b0;
      {chk_mem_ok, chk_bus_ok, chk_batt_ok} = ok;
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      for (i = 0; i < 12 && run_en !== 1'b1; i++) @(negedge clk_sys);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_n, batt_low, fw_upgrade, fw_absent, faulted, debug_online, debug_brk} = '0;
      {io_configured, chk_mem_ok, chk_bus_ok, chk_batt_ok} = '0;
      chk_done = 1'b1;
      err_count = 8'h00;
      miscompares = 0;
      n_compared = 0;
      lfsr = 8'h08;
      // every failing check pattern halts, only the full pass runs
      for (int k = 0; k < 8; k++) begin
         restart(k[2:0]);
         check(8'(run_en), 8'(k == 7));
      end
      apply(8'h40);
      check(red_rises, 8'h01);
      // corner cases, then random condition mixes
      for (int k = 0; k < 40; k++) begin
         lfsr = lfsr_next(lfsr);
         apply(k < 4 ? corner[k] : lfsr);
      end
      tally_and_finish();
   end
endmodule // testbench
